//--- dpgbm_axil_slave.sv
// AXI4-Lite slave front end with 8-bit register strobes
`timescale 1ns/1ns
`include "dpgbm_map.svh"
module dpgbm_axil_slave (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// Write channels
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_stb,
	output logic [2:0] wr_sel,
	output logic [7:0] wr_data,
	output logic [2:0] rd_sel,
	input wire logic [7:0] rd_data
);
	logic [3:0] hold_strb;
	logic do_write;
	assign do_write = !awready && !wready && !bvalid;
	assign wr_stb = do_write && hold_strb[0] && dpgbm_pkg::dpgbm_mapped(wr_sel);
	assign rd_sel = araddr[`DPGBM_SEL_MSB:`DPGBM_SEL_LSB];
	// ----------------------------------------
	// Write address and data, taken in either order
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			wr_sel <= 3'h0;
			wr_data <= 8'h00;
			hold_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `DPGBM_RESP_OKAY;
		end
		else if (ce)
		begin
			if (awready && awvalid)
			begin
				awready <= 1'b0;
				wr_sel <= awaddr[`DPGBM_SEL_MSB:`DPGBM_SEL_LSB];
			end
			if (wready && wvalid)
			begin
				wready <= 1'b0;
				wr_data <= wdata[7:0];
				hold_strb <= wstrb;
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= dpgbm_pkg::dpgbm_mapped(wr_sel) ? `DPGBM_RESP_OKAY : `DPGBM_RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Read, answered at the edge that takes the address
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `DPGBM_RESP_OKAY;
		end
		else if (ce)
		begin
			if (arready && arvalid)
			begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_data};
				rresp <= dpgbm_pkg::dpgbm_mapped(rd_sel) ? `DPGBM_RESP_OKAY : `DPGBM_RESP_SLVERR;
			end
			else if (rvalid && rready)
			begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule : dpgbm_axil_slave

//--- dpgbm_bench.sv
// Self-checking bench of the dual port gpio bus mux
`timescale 1ns/1ns
`include "dpgbm_map.svh"
module dpgbm_bench;
	logic clk_sys = 1'b0, rstn = 1'b0, strap = 1'b0, ce = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, bus_mux;
	logic [1:0] bresp, rresp, resp;
	logic ext_acc = 1'b0, ext_aph = 1'b0, ext_wr = 1'b0;
	logic [15:0] ext_addr = 16'h0, ext_wdata = 16'h0, ext_rdata;
	logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, rd, drv_a = 8'h5a, drv_b = 8'h5a;
	logic [7:0] pb_lat = 8'h00, pb_dir = 8'h00, pb_fc = 8'h00;
	logic [31:0] idx [5] = '{`DPGBM_IDX_PA_LATCH, `DPGBM_IDX_PB_LATCH, `DPGBM_IDX_PA_DIR,
		`DPGBM_IDX_PB_DIR, `DPGBM_IDX_PB_FUNC};
	int n_errors = 0, comparisons = 0, cycles = 0;
	dpgbm_top u_dpgbm_top (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .AWADDR(awaddr), .AWVALID(aw_v),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(w_v), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(b_r), .ARADDR(araddr), .ARVALID(ar_v), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(r_r), .BUS_MODE_STRAP(strap), .EXT_ACCESS(ext_acc),
		.EXT_ADDR_PHASE(ext_aph), .EXT_WRITE(ext_wr), .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata),
		.EXT_RDATA(ext_rdata), .BUS_MODE_MUX(bus_mux), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe),
		.PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe));
	dpgbm_pin_load u_load_a (.clk(clk_sys), .pin_out(pa_out), .pin_oe(pa_oe), .drv_en(1'b1),
		.drv_val(drv_a), .pin_in(pa_in));
	dpgbm_pin_load u_load_b (.clk(clk_sys), .pin_out(pb_out), .pin_oe(pb_oe), .drv_en(1'b1),
		.drv_val(drv_b), .pin_in(pb_in));
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// Verdict, compare and timeout
	// ----------------------------------------
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// AXI4-Lite master, byte address is four times the index
	// ----------------------------------------
	task automatic axi_wr(input logic [31:0] ix, input logic [7:0] d, input logic [3:0] s);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= ix << 2;
		wdata <= {24'h0, d};
		wstrb <= s;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		forever
		begin
			@(posedge clk_sys);
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				aw_v <= 1'b0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				w_v <= 1'b0;
			end
			if (bvalid)
			begin
				resp = bresp;
				break;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] ix);
		logic ar_done;
		ar_done = 1'b0;
		araddr <= ix << 2;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		forever
		begin
			@(posedge clk_sys);
			if (!ar_done && arready)
			begin
				ar_done = 1'b1;
				ar_v <= 1'b0;
			end
			if (rvalid)
			begin
				resp = rresp;
				rd = rdata[7:0];
				check("rdata_upper", rdata[31:8], 24'h0);
				break;
			end
		end
	endtask : axi_rd
	// ----------------------------------------
	// Pin expectations
	// ----------------------------------------
	function automatic logic [15:0] pb_exp(input logic mux);
		logic [15:0] r;
		r = 16'h0;
		for (int i = 0; i < 8; i++)
			case ({pb_fc[i], pb_dir[i]})
				2'h1: r[8+i] = 1'b1;
				2'h2: r[8+i] = ext_acc && ((mux && ext_aph) || ext_wr);
				2'h3: r[8+i] = 1'b1;
				default: r[8+i] = 1'b0;
			endcase
		for (int i = 0; i < 8; i++)
			r[i] = pb_dir[i] ? (pb_fc[i] ? ext_addr[8+i] : pb_lat[i])
				: ((mux && ext_aph) ? ext_addr[8+i] : ext_wdata[8+i]);
		return r;
	endfunction : pb_exp
	task automatic pins(input logic mux);
		logic [15:0] e;
		repeat (3) @(posedge clk_sys);
		e = pb_exp(mux);
		check("pb_oe", pb_oe, e[15:8]);
		check("pb_out", pb_out & e[15:8], e[7:0] & e[15:8]);
		if (ext_acc)
		begin
			check("pa_oe", pa_oe, ((mux && ext_aph) || ext_wr) ? 8'hff : 8'h00);
			if (ext_wr)
				check("pa_out", pa_out, (mux && ext_aph) ? ext_addr[7:0] : ext_wdata[7:0]);
			else
				check("ext_rdata", ext_rdata, {(e[15:8] & e[7:0]) | (~e[15:8] & drv_b), drv_a});
		end
	endtask : pins
	task automatic prog_b();
		axi_wr(`DPGBM_IDX_PB_DIR, pb_dir, 4'hf);
		axi_wr(`DPGBM_IDX_PB_FUNC, pb_fc, 4'hf);
		axi_wr(`DPGBM_IDX_PB_LATCH, pb_lat, 4'hf);
	endtask : prog_b
	task automatic ext_run(input logic mux);
		ext_addr <= 16'hab12;
		ext_wdata <= 16'hcd34;
		{ext_acc, ext_wr, ext_aph} <= 3'b111;
		pins(mux);
		ext_aph <= 1'b0;
		pins(mux);
		{ext_wr, drv_a} <= {1'b0, 8'h77};
		pins(mux);
		ext_acc <= 1'b0;
		pins(mux);
	endtask : ext_run
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("bus_mux", bus_mux, 1'b0);
		check("pa_oe_rst", pa_oe, 8'h00);
		check("pb_oe_rst", pb_oe, 8'h00);
		foreach (idx[i])
		begin
			axi_rd(idx[i]);
			check("reg_rst", {resp, rd}, {`DPGBM_RESP_OKAY, (i < 2) ? 8'h5a : `DPGBM_RST_REG});
		end
		axi_wr(32'h3, 8'hff, 4'hf);
		check("wr_unmapped", resp, `DPGBM_RESP_SLVERR);
		axi_rd(32'h7);
		check("rd_unmapped", {resp, rd}, {`DPGBM_RESP_SLVERR, 8'h00});
		axi_wr(`DPGBM_IDX_PA_DIR, 8'ha5, 4'hf);
		axi_wr(`DPGBM_IDX_PA_LATCH, 8'h3c, 4'hf);
		axi_wr(`DPGBM_IDX_PA_DIR, 8'hff, 4'h0);
		check("wr_nostrb", resp, `DPGBM_RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		check("pa_oe", pa_oe, 8'ha5);
		check("pa_out", pa_out & 8'ha5, 8'h24);
		{ce, ext_acc} <= 2'b01;
		repeat (3) @(posedge clk_sys);
		check("pa_oe_frozen", pa_oe, 8'ha5);
		{ce, ext_acc} <= 2'b10;
		axi_rd(`DPGBM_IDX_PA_LATCH);
		check("pa_latch_rd", rd, 8'h3c & 8'ha5 | 8'h5a & 8'h5a);
		{pb_dir, pb_fc, pb_lat} = {8'haa, 8'hcc, 8'hff};
		prog_b();
		pins(1'b0);
		axi_rd(`DPGBM_IDX_PB_LATCH);
		check("pb_latch_rd", rd, 8'h22 | 8'h5a & 8'h55);
		ext_run(1'b0);
		axi_rd(`DPGBM_IDX_PA_DIR);
		check("pa_dir_clr", rd, 8'h00);
		strap <= 1'b1;
		rstn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("bus_mux", bus_mux, 1'b1);
		axi_rd(`DPGBM_IDX_PB_FUNC);
		check("pb_fc_rst", rd, 8'h00);
		{pb_dir, pb_fc, pb_lat} = {8'h5c, 8'hf0, 8'h0f};
		prog_b();
		ext_run(1'b1);
		report_and_stop();
	end
endmodule : dpgbm_bench

//--- dpgbm_map.svh
// Offsets, field values and reset values of the dual port gpio bus mux
// What this block does
// - Port A direction bit: 0 input, 1 output
// - Reset clears port A direction register
// - External access turns port A into bus
// - External access clears port A direction register
// - Strap low: port A carries data 7..0
// - Strap high: port A carries address/data 7..0
// - Port B role per bit from function/direction
// - Reset clears port B latch, direction, function
// - Port B pair: input, output, bus, address
// - Separate mode pair 10: data 15..8
// - Multiplexed mode pair 10: address/data 15..8
// - Pair 11: output-only address 15..8
// - Strap selects port B separate or multiplexed
`ifndef DPGBM_MAP_SVH
`define DPGBM_MAP_SVH
// ----------------------------------------
// Register indexes, byte address is four times the index
// ----------------------------------------
`define DPGBM_IDX_PA_LATCH 32'hfffff000
`define DPGBM_IDX_PB_LATCH 32'hfffff001
`define DPGBM_IDX_PA_DIR 32'hfffff002
`define DPGBM_IDX_PB_DIR 32'hfffff004
`define DPGBM_IDX_PB_FUNC 32'hfffff005
`define DPGBM_SEL_MSB 4
`define DPGBM_SEL_LSB 2
// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define DPGBM_RST_REG 8'h00
`define DPGBM_RESP_OKAY 2'h0
`define DPGBM_RESP_SLVERR 2'h2
`endif

//--- dpgbm_pin_load.sv
// Pin load model: far side of one 8-bit port
`timescale 1ns/1ns
module dpgbm_pin_load (
	// Clock
	input wire logic clk,
	// Design pins
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Far side drive
	input wire logic drv_en,
	input wire logic [7:0] drv_val,
	// Wire level
	output logic [7:0] pin_in
);
	logic [7:0] last;
	// Released lines show drv_val, or the inverse of the last level when drv_en is low
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (drv_en ? drv_val : ~last));
	always @(posedge clk)
	begin
		last <= pin_in;
	end
endmodule : dpgbm_pin_load

//--- dpgbm_pin_mux.sv
// Registered pin driver for one 8-bit port
`timescale 1ns/1ns
module dpgbm_pin_mux #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// Pin roles and sources
	input wire dpgbm_pkg::dpgbm_role_type role [WIDTH],
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] bus_addr,
	input wire logic [WIDTH-1:0] bus_data,
	input wire logic bus_mux,
	input wire logic ext_access,
	input wire logic ext_addr_phase,
	input wire logic ext_write,
	// Pins
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe
);
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge clk_sys or negedge rstn)
		begin
			if (!rstn)
			begin
				pin_out[i] <= 1'b0;
				pin_oe[i] <= 1'b0;
			end
			else if (ce)
			begin
				unique case (role[i])
					dpgbm_pkg::DPGBM_ROLE_IN:
					begin
						pin_out[i] <= latch[i];
						pin_oe[i] <= 1'b0;
					end
					dpgbm_pkg::DPGBM_ROLE_OUT:
					begin
						pin_out[i] <= latch[i];
						pin_oe[i] <= 1'b1;
					end
					dpgbm_pkg::DPGBM_ROLE_BUS:
					begin
						if (ext_access && bus_mux && ext_addr_phase)
						begin
							pin_out[i] <= bus_addr[i];
							pin_oe[i] <= 1'b1;
						end
						else
						begin
							pin_out[i] <= bus_data[i];
							pin_oe[i] <= ext_access && ext_write;
						end
					end
					dpgbm_pkg::DPGBM_ROLE_ADDR:
					begin
						pin_out[i] <= bus_addr[i];
						pin_oe[i] <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule : dpgbm_pin_mux

//--- dpgbm_pkg.sv
// Types and decode functions of the dual port gpio bus mux
`include "dpgbm_map.svh"
package dpgbm_pkg;
	typedef enum logic [3:0] {
		DPGBM_ROLE_IN = 4'h1,
		DPGBM_ROLE_OUT = 4'h2,
		DPGBM_ROLE_BUS = 4'h4,
		DPGBM_ROLE_ADDR = 4'h8
	} dpgbm_role_type;
	typedef enum logic [1:0] {
		DPGBM_BUS_SEPARATE = 2'h1,
		DPGBM_BUS_MUX = 2'h2
	} dpgbm_bus_type;
	// Function/direction pair to pin role
	function automatic dpgbm_role_type dpgbm_role(input logic fc, input logic cr);
		unique case ({fc, cr})
			2'h0: return DPGBM_ROLE_IN;
			2'h1: return DPGBM_ROLE_OUT;
			2'h2: return DPGBM_ROLE_BUS;
			default: return DPGBM_ROLE_ADDR;
		endcase
	endfunction : dpgbm_role
	// Address select bits of a register index
	function automatic logic [2:0] dpgbm_sel(input logic [31:0] idx);
		return idx[2:0];
	endfunction : dpgbm_sel
	function automatic logic dpgbm_mapped(input logic [2:0] sel);
		return sel == dpgbm_sel(`DPGBM_IDX_PA_LATCH) || sel == dpgbm_sel(`DPGBM_IDX_PB_LATCH)
			|| sel == dpgbm_sel(`DPGBM_IDX_PA_DIR) || sel == dpgbm_sel(`DPGBM_IDX_PB_DIR)
			|| sel == dpgbm_sel(`DPGBM_IDX_PB_FUNC);
	endfunction : dpgbm_mapped
endpackage : dpgbm_pkg

//--- dpgbm_top.sv
// Top of the dual port gpio bus mux: registers, strap, pins
`timescale 1ns/1ns
`include "dpgbm_map.svh"
module dpgbm_top (
	// Clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic CE,
	// AXI4-Lite write
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// External bus controller
	input wire logic BUS_MODE_STRAP,
	input wire logic EXT_ACCESS,
	input wire logic EXT_ADDR_PHASE,
	input wire logic EXT_WRITE,
	input wire logic [15:0] EXT_ADDR,
	input wire logic [15:0] EXT_WDATA,
	output logic [15:0] EXT_RDATA,
	output logic BUS_MODE_MUX,
	// Port A pins
	input wire logic [7:0] PA_IN,
	output logic [7:0] PA_OUT,
	output logic [7:0] PA_OE,
	// Port B pins
	input wire logic [7:0] PB_IN,
	output logic [7:0] PB_OUT,
	output logic [7:0] PB_OE
);
	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [7:0] pa_latch;
	logic [7:0] pb_latch;
	logic [7:0] pa_dir;
	logic [7:0] pb_dir;
	logic [7:0] pb_func;
	logic strap_done;
	dpgbm_pkg::dpgbm_bus_type bus_mode;
	dpgbm_pkg::dpgbm_role_type pa_role [8];
	dpgbm_pkg::dpgbm_role_type pb_role [8];
	logic wr_stb;
	logic [2:0] wr_sel;
	logic [7:0] wr_data;
	logic [2:0] rd_sel;
	logic [7:0] rd_data;
	logic bus_mux;
	assign bus_mux = bus_mode == dpgbm_pkg::DPGBM_BUS_MUX;

	// Latch for bits in the output role, pin level for all other bits
	function automatic logic [7:0] readback(input logic [7:0] pins, input logic [7:0] latch,
		input logic [7:0] fc, input logic [7:0] cr);
		logic [7:0] r;
		r = pins;
		for (int i = 0; i < 8; i++)
		begin
			if (dpgbm_pkg::dpgbm_role(fc[i], cr[i]) == dpgbm_pkg::DPGBM_ROLE_OUT)
			begin
				r[i] = latch[i];
			end
		end
		return r;
	endfunction : readback

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	dpgbm_axil_slave u_slave (
		.clk_sys(CLK_SYS),
		.rstn(RSTN),
		.ce(CE),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.wr_stb(wr_stb),
		.wr_sel(wr_sel),
		.wr_data(wr_data),
		.rd_sel(rd_sel),
		.rd_data(rd_data)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rd_data = 8'h00;
		if (rd_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PA_LATCH))
		begin
			rd_data = readback(PA_IN, pa_latch, 8'h00, pa_dir);
		end
		else if (rd_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_LATCH))
		begin
			rd_data = readback(PB_IN, pb_latch, pb_func, pb_dir);
		end
		else if (rd_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PA_DIR))
		begin
			rd_data = pa_dir;
		end
		else if (rd_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_DIR))
		begin
			rd_data = pb_dir;
		end
		else if (rd_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_FUNC))
		begin
			rd_data = pb_func;
		end
	end

	// ----------------------------------------
	// Port A registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pa_latch <= `DPGBM_RST_REG;
			pa_dir <= `DPGBM_RST_REG;
		end
		else if (CE)
		begin
			if (wr_stb && wr_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PA_LATCH))
			begin
				pa_latch <= wr_data;
			end
			if (EXT_ACCESS)
			begin
				pa_dir <= `DPGBM_RST_REG;
			end
			else if (wr_stb && wr_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PA_DIR))
			begin
				pa_dir <= wr_data;
			end
		end
	end

	// ----------------------------------------
	// Port B registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pb_latch <= `DPGBM_RST_REG;
			pb_dir <= `DPGBM_RST_REG;
			pb_func <= `DPGBM_RST_REG;
		end
		else if (CE && wr_stb)
		begin
			if (wr_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_LATCH))
			begin
				pb_latch <= wr_data;
			end
			if (wr_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_DIR))
			begin
				pb_dir <= wr_data;
			end
			if (wr_sel == dpgbm_pkg::dpgbm_sel(`DPGBM_IDX_PB_FUNC))
			begin
				pb_func <= wr_data;
			end
		end
	end

	// ----------------------------------------
	// Bus mode strap, caught at the first enabled edge after reset
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			strap_done <= 1'b0;
			bus_mode <= dpgbm_pkg::DPGBM_BUS_SEPARATE;
			BUS_MODE_MUX <= 1'b0;
		end
		else if (CE && !strap_done)
		begin
			strap_done <= 1'b1;
			bus_mode <= BUS_MODE_STRAP ? dpgbm_pkg::DPGBM_BUS_MUX : dpgbm_pkg::DPGBM_BUS_SEPARATE;
			BUS_MODE_MUX <= BUS_MODE_STRAP;
		end
	end

	// ----------------------------------------
	// Pin roles and drivers
	// ----------------------------------------
	for (genvar i = 0; i < 8; i++)
	begin : g_role
		assign pa_role[i] = EXT_ACCESS ? dpgbm_pkg::DPGBM_ROLE_BUS
			: dpgbm_pkg::dpgbm_role(1'b0, pa_dir[i]);
		assign pb_role[i] = dpgbm_pkg::dpgbm_role(pb_func[i], pb_dir[i]);
	end

	dpgbm_pin_mux #(
		.WIDTH(8)
	) u_port_a (
		.clk_sys(CLK_SYS),
		.rstn(RSTN),
		.ce(CE),
		.role(pa_role),
		.latch(pa_latch),
		.bus_addr(EXT_ADDR[7:0]),
		.bus_data(EXT_WDATA[7:0]),
		.bus_mux(bus_mux),
		.ext_access(EXT_ACCESS),
		.ext_addr_phase(EXT_ADDR_PHASE),
		.ext_write(EXT_WRITE),
		.pin_out(PA_OUT),
		.pin_oe(PA_OE)
	);

	dpgbm_pin_mux #(
		.WIDTH(8)
	) u_port_b (
		.clk_sys(CLK_SYS),
		.rstn(RSTN),
		.ce(CE),
		.role(pb_role),
		.latch(pb_latch),
		.bus_addr(EXT_ADDR[15:8]),
		.bus_data(EXT_WDATA[15:8]),
		.bus_mux(bus_mux),
		.ext_access(EXT_ACCESS),
		.ext_addr_phase(EXT_ADDR_PHASE),
		.ext_write(EXT_WRITE),
		.pin_out(PB_OUT),
		.pin_oe(PB_OE)
	);

	// ----------------------------------------
	// Read data returned to the bus controller
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			EXT_RDATA <= 16'h0000;
		end
		else if (CE && EXT_ACCESS && !EXT_WRITE)
		begin
			EXT_RDATA <= {PB_IN, PA_IN};
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pa_dir_pins_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && !EXT_ACCESS |=> PA_OE == $past(pa_dir))
		else $error("port A enables differ from direction");
	regs_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!strap_done |-> pa_dir == 8'h00 && pb_dir == 8'h00 && pb_func == 8'h00 && pb_latch == 8'h00)
		else $error("registers not clear after reset");
	ext_dir_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS |=> pa_dir == 8'h00)
		else $error("direction kept during access");
	pa_data_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS && EXT_WRITE && !(bus_mux && EXT_ADDR_PHASE)
		|=> PA_OE == 8'hff && PA_OUT == $past(EXT_WDATA[7:0]))
		else $error("port A not driving write data");
	pa_mux_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS && EXT_ADDR_PHASE && bus_mux
		|=> PA_OE == 8'hff && PA_OUT == $past(EXT_ADDR[7:0]))
		else $error("port A not driving address");
	pa_sep_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS && !EXT_WRITE && !bus_mux |=> PA_OE == 8'h00)
		else $error("port A drives during read");
	pb_addr_role_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && pb_func[3] && pb_dir[3] |=> PB_OE[3] && PB_OUT[3] == $past(EXT_ADDR[11]))
		else $error("port B address line wrong");
	pb_gpio_out_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && !pb_func[0] |=> PB_OE[0] == $past(pb_dir[0]) && (!PB_OE[0] || PB_OUT[0] == $past(pb_latch[0])))
		else $error("port B gpio bit wrong");
	pb_sep_data_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && pb_func[6] && !pb_dir[6] && !bus_mux && EXT_ACCESS
		|=> PB_OE[6] == $past(EXT_WRITE) && (!PB_OE[6] || PB_OUT[6] == $past(EXT_WDATA[14])))
		else $error("port B data line wrong");
	pb_mux_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && pb_func[7] && !pb_dir[7] && bus_mux && EXT_ACCESS && EXT_ADDR_PHASE
		|=> PB_OE[7] && PB_OUT[7] == $past(EXT_ADDR[15]))
		else $error("port B address/data line wrong");
	strap_mode_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		$rose(strap_done) |-> BUS_MODE_MUX == $past(BUS_MODE_STRAP) && bus_mux == BUS_MODE_MUX)
		else $error("bus mode not from strap");
	strap_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		strap_done |=> $stable(BUS_MODE_MUX) && $stable(bus_mode))
		else $error("bus mode changed after reset");
	pa_mux_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS && !EXT_WRITE && bus_mux && !EXT_ADDR_PHASE |=> PA_OE == 8'h00)
		else $error("port A drives during data read");
	pa_gpio_out_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && !EXT_ACCESS |=> (PA_OUT & PA_OE) == ($past(pa_latch) & PA_OE))
		else $error("port A output differs from latch");
	ext_rdata_cap_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CE && EXT_ACCESS && !EXT_WRITE |=> EXT_RDATA == {$past(PB_IN), $past(PA_IN)})
		else $error("external read data not captured");
	ce_freeze_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!CE |=> $stable(PA_OE) && $stable(PA_OUT) && $stable(PB_OE) && $stable(PB_OUT)
			&& $stable(pa_dir) && $stable(EXT_RDATA) && $stable(BVALID) && $stable(RVALID))
		else $error("state moved while clock enable low");

	// Per-bit port B roles
	for (genvar i = 0; i < 8; i++)
	begin : g_pb_check
		pb_in_role_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
			CE && !pb_func[i] && !pb_dir[i] |=> !PB_OE[i])
			else $error("port B input bit drives");
		pb_addr_bit_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
			CE && pb_func[i] && pb_dir[i] |=> PB_OE[i] && PB_OUT[i] == $past(EXT_ADDR[8 + i]))
			else $error("port B address bit wrong");
		pb_bus_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
			CE && pb_func[i] && !pb_dir[i] && !EXT_ACCESS |=> !PB_OE[i])
			else $error("port B bus bit drives while idle");
	end
endmodule : dpgbm_top
